/* File: pkg/sffc_pkg.sv */
// package: layout, offsets, reset values and carriers of the frame format block
//
// Function
// - mode bit clear selects asynchronous framing, set selects clocked synchronous framing
// - asynchronous: length bit clear gives 8-bit characters, set gives 7-bit
// - 7-bit characters go lsb first; top bit of the holding byte is dropped
// - synchronous mode always uses 8-bit characters, length bit ignored
// - asynchronous with parity on: add parity bit on send, check it on receive
// - addressed framing disables parity generation and checking regardless of parity bits
// - active parity is even when sense bit is clear, odd when set
// - asynchronous send uses one stop bit, or two when stop bit set
// - receiver checks first stop bit only; low second stop starts next frame
// - asynchronous addressed framing adds an address/data indicator bit to each frame
// - prescaler codes 0..3 divide the clock by 1, 4, 16, 64; index exported
// - address wait drops indicator-0 frames silently, clears itself on indicator-1 frame
package sffc_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;

  localparam logic [ADDR_W-1:0] OFF_MODE = 2'h0;
  localparam logic [ADDR_W-1:0] OFF_WAIT = 2'h1;
  localparam logic [ADDR_W-1:0] OFF_STAT = 2'h2;

  localparam int POS_WAIT_EN = 0;
  localparam int POS_STAT_PERR = 0;
  localparam int POS_STAT_FERR = 1;
  localparam int POS_STAT_MARK = 2;
  localparam int POS_STAT_WAIT = 3;

  localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] MASK_7BIT = 8'h7F;
  localparam logic [DATA_W-1:0] MASK_8BIT = 8'hFF;
  localparam logic [3:0] LEN_7 = 4'h7;
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [1:0] STOP_1 = 2'h1;
  localparam logic [1:0] STOP_2 = 2'h2;

  // prescaler terminal counts, one less than the division ratio
  localparam int PRESC_W = 6;
  localparam logic [PRESC_W-1:0] PRESC_LIM_0 = 6'h00;
  localparam logic [PRESC_W-1:0] PRESC_LIM_1 = 6'h03;
  localparam logic [PRESC_W-1:0] PRESC_LIM_2 = 6'h0F;
  localparam logic [PRESC_W-1:0] PRESC_LIM_3 = 6'h3F;

  typedef enum logic {
    SFFC_ASYNC = 1'b0,
    SFFC_SYNC = 1'b1
  } sffc_comm_t;

  // bit 7 down to bit 0 of serial_format_mode
  typedef struct packed {
    sffc_comm_t comm_mode;
    logic char_length_select;
    logic parity_on;
    logic parity_odd_select;
    logic stop_length_select;
    logic addressed_framing_enable;
    logic prescaler_select_hi;
    logic prescaler_select_lo;
  } sffc_mode_t;

  typedef struct packed {
    logic sync_mode;
    logic [3:0] data_bits;
    logic parity_active;
    logic parity_odd;
    logic [1:0] stop_bits;
    logic addr_mode;
    logic [1:0] presc_idx;
  } sffc_cfg_t;

  typedef struct packed {
    logic load;
    logic [DATA_W-1:0] data;
    logic addr_mark;
  } sffc_tx_in_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic parity_en;
    logic parity_bit;
    logic addr_mark_en;
    logic addr_mark;
    logic [1:0] stop_bits;
  } sffc_tx_out_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic parity_bit;
    logic addr_mark;
    logic stop_bit;
  } sffc_rx_in_t;

  typedef struct packed {
    logic accept;
    logic discard;
    logic [DATA_W-1:0] data;
    logic parity_err;
    logic frame_err;
    logic addr_mark;
  } sffc_rx_out_t;

  localparam sffc_cfg_t CFG_RESET = '{sync_mode: 1'b0, data_bits: LEN_8,
      parity_active: 1'b0, parity_odd: 1'b0, stop_bits: STOP_1,
      addr_mode: 1'b0, presc_idx: 2'h0};
endpackage

/* File: rtl/sffc_prescaler.sv */
// prescaler feeding the baud rate generator: divides the clock by 1, 4, 16 or 64
`timescale 1ns/1ps
module sffc_prescaler (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [1:0] i_idx,
  output logic o_tick
);
  import sffc_pkg::*;

  typedef struct packed {
    logic [PRESC_W-1:0] cnt;
    logic [1:0] idx;
    logic tick;
  } sffc_presc_st_t;

  sffc_presc_st_t r;
  sffc_presc_st_t n;

  function automatic logic [PRESC_W-1:0] limit_of(input logic [1:0] idx);
    logic [PRESC_W-1:0] lim;
    unique case (idx)
      2'h0: lim = PRESC_LIM_0;
      2'h1: lim = PRESC_LIM_1;
      2'h2: lim = PRESC_LIM_2;
      2'h3: lim = PRESC_LIM_3;
    endcase
    return lim;
  endfunction

  always_comb begin
    n = r;
    n.idx = i_idx;
    // restart on a tap change so the first period is never a stale one
    if (i_idx != r.idx || r.cnt >= limit_of(i_idx)) begin
      n.cnt = '0;
    end else begin
      n.cnt = r.cnt + 6'h01;
    end
    n.tick = (i_idx == r.idx) && (r.cnt >= limit_of(i_idx));
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_tick = r.tick;

  property p_div4;
    @(posedge i_clock) disable iff (!i_rstn)
      (o_tick && i_idx == 2'h1 && $past(i_idx) == 2'h1) ##1 (i_idx == 2'h1) [*4] |->
        o_tick && !$past(o_tick);
  endproperty
  a_div4: assert property (p_div4) else $error("divide by 4 period wrong");

  property p_div1;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_idx == 2'h0) [*2] |=> o_tick;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by 1 missed a tick");
endmodule

/* File: rtl/sffc_frame_format.sv */
// serial frame format configuration: mode register, framing decode, tx/rx frame shaping
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module sffc_frame_format #(
  parameter int AW = sffc_pkg::ADDR_W
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [AW-1:0] i_addr,
  input wire logic [sffc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [sffc_pkg::DATA_W-1:0] o_rdata,
  input wire sffc_pkg::sffc_tx_in_t i_tx,
  output sffc_pkg::sffc_tx_out_t o_tx,
  input wire sffc_pkg::sffc_rx_in_t i_rx,
  output sffc_pkg::sffc_rx_out_t o_rx,
  output sffc_pkg::sffc_cfg_t o_cfg,
  output logic o_presc_tick
);
  import sffc_pkg::*;

  typedef struct packed {
    sffc_mode_t mode;
    logic wait_en;
    logic last_perr;
    logic last_ferr;
    logic last_addr_mark;
    sffc_cfg_t cfg;
    sffc_tx_out_t tx;
    sffc_rx_out_t rx;
    logic [DATA_W-1:0] rdata;
  } sffc_st_t;

  localparam sffc_st_t ST_RESET = '{mode: sffc_mode_t'(MODE_RESET), wait_en: 1'b0,
      last_perr: 1'b0, last_ferr: 1'b0, last_addr_mark: 1'b0, cfg: CFG_RESET,
      tx: '0, rx: '0, rdata: '0};

  sffc_st_t r;
  sffc_st_t n;
  logic skip;
  logic wait_hit;
  logic [DATA_W-1:0] rx_data;

  // the whole format follows from the stored mode byte
  function automatic sffc_cfg_t decode_cfg(input sffc_mode_t m);
    sffc_cfg_t c;
    c.sync_mode = (m.comm_mode == SFFC_SYNC);
    if (c.sync_mode) begin
      c.data_bits = LEN_8;
    end else begin
      c.data_bits = m.char_length_select ? LEN_7 : LEN_8;
    end
    c.addr_mode = !c.sync_mode && m.addressed_framing_enable;
    // addressed framing overrides both parity bits
    c.parity_active = !c.sync_mode && m.parity_on && !c.addr_mode;
    c.parity_odd = c.parity_active && m.parity_odd_select;
    c.stop_bits = (!c.sync_mode && m.stop_length_select) ? STOP_2 : STOP_1;
    c.presc_idx = {m.prescaler_select_hi, m.prescaler_select_lo};
    return c;
  endfunction

  function automatic logic [DATA_W-1:0] len_mask(input sffc_cfg_t c);
    return (c.data_bits == LEN_7) ? MASK_7BIT : MASK_8BIT;
  endfunction

  // even sense makes the total count of ones even
  function automatic logic parity_of(input logic [DATA_W-1:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  always_comb begin
    n = r;
    skip = 1'b0;
    wait_hit = 1'b0;
    rx_data = i_rx.data & len_mask(r.cfg);
    n.rdata = '0;
    n.cfg = decode_cfg(r.mode);

    // transmit side: shape the holding byte into frame fields
    n.tx.valid = i_tx.load;
    if (i_tx.load) begin
      n.tx.data = i_tx.data & len_mask(r.cfg);
      n.tx.parity_en = r.cfg.parity_active;
      n.tx.parity_bit = r.cfg.parity_active &&
          parity_of(i_tx.data & len_mask(r.cfg), r.cfg.parity_odd);
      n.tx.addr_mark_en = r.cfg.addr_mode;
      n.tx.addr_mark = r.cfg.addr_mode && i_tx.addr_mark;
      n.tx.stop_bits = r.cfg.stop_bits;
    end

    // receive side: one-cycle pulses; a skipped frame raises only the discard pulse
    n.rx.accept = 1'b0;
    n.rx.discard = 1'b0;
    n.rx.parity_err = 1'b0;
    n.rx.frame_err = 1'b0;
    if (i_rx.valid) begin
      skip = r.cfg.addr_mode && r.wait_en && !i_rx.addr_mark;
      wait_hit = r.cfg.addr_mode && r.wait_en && i_rx.addr_mark;
      if (skip) begin
        n.rx.discard = 1'b1;
      end else begin
        n.rx.accept = 1'b1;
        n.rx.data = rx_data;
        n.rx.addr_mark = r.cfg.addr_mode && i_rx.addr_mark;
        n.rx.parity_err = r.cfg.parity_active &&
            (i_rx.parity_bit != parity_of(rx_data, r.cfg.parity_odd));
        // only the first stop bit counts; a second low one is the next start
        n.rx.frame_err = !r.cfg.sync_mode && !i_rx.stop_bit;
        n.last_perr = n.rx.parity_err;
        n.last_ferr = n.rx.frame_err;
        n.last_addr_mark = n.rx.addr_mark;
      end
      if (wait_hit) begin
        n.wait_en = 1'b0;
      end
    end

    // a software write in the same cycle outranks the automatic clear
    if (i_wr) begin
      unique case (i_addr)
        OFF_MODE: n.mode = sffc_mode_t'(i_wdata);
        OFF_WAIT: n.wait_en = i_wdata[POS_WAIT_EN];
        default: n.mode = r.mode;
      endcase
    end

    // reads only copy state out
    if (i_rd) begin
      unique case (i_addr)
        OFF_MODE: n.rdata = r.mode;
        OFF_WAIT: n.rdata[POS_WAIT_EN] = r.wait_en;
        OFF_STAT: begin
          n.rdata[POS_STAT_PERR] = r.last_perr;
          n.rdata[POS_STAT_FERR] = r.last_ferr;
          n.rdata[POS_STAT_MARK] = r.last_addr_mark;
          n.rdata[POS_STAT_WAIT] = r.wait_en;
        end
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      r <= ST_RESET;
    end else begin
      r <= n;
    end
  end

  sffc_prescaler u_presc (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_idx(r.cfg.presc_idx),
    .o_tick(o_presc_tick)
  );

  assign o_rdata = r.rdata;
  assign o_tx = r.tx;
  assign o_rx = r.rx;
  assign o_cfg = r.cfg;

  property p_mode_sel;
    @(posedge i_clock) disable iff (!i_rstn)
      ##1 o_cfg.sync_mode == ($past(r.mode.comm_mode) == SFFC_SYNC);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("framing mode not from mode bit");

  property p_async_len;
    @(posedge i_clock) disable iff (!i_rstn)
      (r.mode.comm_mode == SFFC_ASYNC) |=>
        o_cfg.data_bits == ($past(r.mode.char_length_select) ? LEN_7 : LEN_8);
  endproperty
  a_async_len: assert property (p_async_len) else $error("async length wrong");

  property p_tx_top_drop;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_tx.load && r.cfg.data_bits == LEN_7) |=> o_tx.valid && !o_tx.data[DATA_W-1];
  endproperty
  a_tx_top_drop: assert property (p_tx_top_drop) else $error("7-bit top bit sent");

  property p_sync_len;
    @(posedge i_clock) disable iff (!i_rstn)
      o_cfg.sync_mode |-> o_cfg.data_bits == LEN_8 && !o_cfg.parity_active;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync mode not plain 8 bits");

  property p_tx_parity;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_tx.load && r.cfg.parity_active) |=>
        o_tx.parity_en && o_tx.parity_bit == ((^o_tx.data) ^ $past(r.cfg.parity_odd));
  endproperty
  a_tx_parity: assert property (p_tx_parity) else $error("tx parity bit wrong");

  property p_addr_no_parity;
    @(posedge i_clock) disable iff (!i_rstn)
      (r.mode.addressed_framing_enable && r.mode.comm_mode == SFFC_ASYNC) |=>
        !o_cfg.parity_active ##1 !(o_rx.parity_err || (o_tx.valid && o_tx.parity_en));
  endproperty
  a_addr_no_parity: assert property (p_addr_no_parity) else $error("parity on addr");

  property p_rx_parity;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_rx.valid && !skip && r.cfg.parity_active && r.cfg.parity_odd &&
        ((^rx_data) == i_rx.parity_bit)) |=> o_rx.accept && o_rx.parity_err;
  endproperty
  a_rx_parity: assert property (p_rx_parity) else $error("odd parity error missed");

  property p_stop_len;
    @(posedge i_clock) disable iff (!i_rstn)
      (r.mode.stop_length_select && r.mode.comm_mode == SFFC_ASYNC) |=>
        o_cfg.stop_bits == STOP_2;
  endproperty
  a_stop_len: assert property (p_stop_len) else $error("two stop bits not set");

  property p_stop_first;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_rx.valid && !skip && i_rx.stop_bit) |=> o_rx.accept && !o_rx.frame_err;
  endproperty
  a_stop_first: assert property (p_stop_first) else $error("good stop flagged");

  property p_skip;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_rx.valid && r.cfg.addr_mode && r.wait_en && !i_rx.addr_mark) |=>
        o_rx.discard && !o_rx.accept && !o_rx.parity_err && !o_rx.frame_err;
  endproperty
  a_skip: assert property (p_skip) else $error("indicator-0 frame not dropped");

  property p_wait_clear;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_rx.valid && r.cfg.addr_mode && r.wait_en && i_rx.addr_mark && !i_wr) |=>
        !r.wait_en && o_rx.accept;
  endproperty
  a_wait_clear: assert property (p_wait_clear) else $error("address wait not cleared");

  property p_read_mode;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_rd && i_addr == OFF_MODE) |=> o_rdata == $past(r.mode) && $stable(r.mode);
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("mode read wrong");

  property p_reset_out;
    @(posedge i_clock)
      !i_rstn |=> o_cfg == CFG_RESET && o_rdata == '0 && !o_tx.valid && !o_rx.accept &&
        !o_rx.discard && !o_presc_tick;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared");

  property p_read_idle;
    @(posedge i_clock) disable iff (!i_rstn)
      !i_rd |=> o_rdata == '0;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data left standing");

  property p_presc_idx;
    @(posedge i_clock) disable iff (!i_rstn)
      ##1 o_cfg.presc_idx == $past({r.mode.prescaler_select_hi, r.mode.prescaler_select_lo});
  endproperty
  a_presc_idx: assert property (p_presc_idx) else $error("prescaler index wrong");

  property p_tx_8bit;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_tx.load && r.cfg.data_bits == LEN_8) |=>
        o_tx.valid && o_tx.data == $past(i_tx.data);
  endproperty
  a_tx_8bit: assert property (p_tx_8bit) else $error("8-bit byte altered");

  property p_addr_cfg;
    @(posedge i_clock) disable iff (!i_rstn)
      (r.mode.addressed_framing_enable && r.mode.comm_mode == SFFC_ASYNC) |=>
        o_cfg.addr_mode;
  endproperty
  a_addr_cfg: assert property (p_addr_cfg) else $error("addressed framing not on");

  property p_tx_mark;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_tx.load && r.cfg.addr_mode) |=>
        o_tx.addr_mark_en && o_tx.addr_mark == $past(i_tx.addr_mark);
  endproperty
  a_tx_mark: assert property (p_tx_mark) else $error("indicator bit not sent");

  property p_tx_no_mark;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_tx.load && !r.cfg.addr_mode) |=> !o_tx.addr_mark_en && !o_tx.addr_mark;
  endproperty
  a_tx_no_mark: assert property (p_tx_no_mark) else $error("stray indicator bit");

  property p_rx_even;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_rx.valid && !skip && r.cfg.parity_active && !r.cfg.parity_odd &&
        ((^rx_data) != i_rx.parity_bit)) |=> o_rx.accept && o_rx.parity_err;
  endproperty
  a_rx_even: assert property (p_rx_even) else $error("even parity error missed");

  property p_rx_no_parity;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_rx.valid && !r.cfg.parity_active) |=> !o_rx.parity_err;
  endproperty
  a_rx_no_parity: assert property (p_rx_no_parity) else $error("parity checked while off");

  property p_sync_no_ferr;
    @(posedge i_clock) disable iff (!i_rstn)
      (i_rx.valid && r.cfg.sync_mode) |=> !o_rx.frame_err;
  endproperty
  a_sync_no_ferr: assert property (p_sync_no_ferr) else $error("framing error in sync");
endmodule

/* File: dv/sffc_remote_model.sv */
// remote serial chip model: echoes each shaped transmit frame back as a received frame
`timescale 1ns/1ps
module sffc_remote_model (
  input wire logic i_clock,
  input wire sffc_pkg::sffc_tx_out_t i_tx,
  input wire logic i_slow,
  input wire logic i_flip_par,
  input wire logic i_bad_stop,
  output sffc_pkg::sffc_rx_in_t o_rx
);
  import sffc_pkg::*;
  sffc_rx_in_t hold_reg;
  sffc_rx_in_t frame;
  initial o_rx = '0;
  always_comb begin
    frame.valid = 1'b1;
    frame.data = i_tx.data;
    frame.parity_bit = i_tx.parity_bit ^ i_flip_par;
    frame.addr_mark = i_tx.addr_mark;
    frame.stop_bit = ~i_bad_stop;
  end
  // slow path answers one cycle later; idle data toggles so stale values never match
  always @(posedge i_clock) begin
    hold_reg <= '{valid: i_tx.valid & i_slow, data: frame.data, parity_bit: frame.parity_bit,
      addr_mark: frame.addr_mark, stop_bit: frame.stop_bit};
    if (i_tx.valid & ~i_slow) begin
      o_rx <= frame;
    end else if (hold_reg.valid) begin
      o_rx <= hold_reg;
    end else begin
      o_rx.valid <= 1'b0;
      o_rx.data <= ~o_rx.data;
    end
  end
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the frame format block with a remote chip model
`timescale 1ns/1ps
module tb_top;
  import sffc_pkg::*;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  sffc_tx_in_t tx_in = '0;
  sffc_tx_out_t tx_out;
  sffc_rx_in_t rx_in;
  sffc_rx_out_t rx_out;
  sffc_cfg_t cfg;
  logic tick;
  logic slow = 1'b0;
  logic flip = 1'b0;
  logic bad = 1'b0;
  logic sy, pa, od, mpa, c7, st2, wen;
  logic [7:0] last = 8'h00;
  logic last_mark = 1'b0;
  sffc_cfg_t exp_cfg;
  logic [7:0] rv;
  int fail_count = 0;
  int cmp_count = 0;
  logic [15:0] tx_q[$];
  logic [15:0] rx_q[$];
  wire [15:0] tx_seen = {2'b00, tx_out.data, tx_out.parity_en, tx_out.parity_bit,
    tx_out.addr_mark_en, tx_out.addr_mark, tx_out.stop_bits};
  wire [15:0] rx_seen = {3'b000, rx_out.accept, rx_out.discard, rx_out.parity_err,
    rx_out.frame_err, rx_out.addr_mark, rx_out.data};
  logic [7:0] modes[6] = '{8'h00, 8'h70, 8'hC0, 8'h34, 8'h48, 8'h38};
  always #2 i_clock = ~i_clock;
  sffc_frame_format uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx(tx_in), .o_tx(tx_out), .i_rx(rx_in),
    .o_rx(rx_out), .o_cfg(cfg), .o_presc_tick(tick));
  sffc_remote_model peer (.i_clock(i_clock), .i_tx(tx_out), .i_slow(slow),
    .i_flip_par(flip), .i_bad_stop(bad), .o_rx(rx_in));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic set_mode(input logic [7:0] m);
    reg_wr(OFF_MODE, m);
    reg_rd(OFF_MODE, rv);
    check({4'h0, rv}, {4'h0, m});
    sy = m[7];
    c7 = !sy && m[6];
    mpa = !sy && m[2];
    pa = !sy && m[5] && !m[2];
    od = pa && m[4];
    st2 = !sy && m[3];
    exp_cfg = {sy, c7 ? LEN_7 : LEN_8, pa, od, st2 ? STOP_2 : STOP_1, mpa, m[1:0]};
    check(cfg, exp_cfg);
  endtask
  task automatic send(input logic [7:0] d, input logic mpb, input logic f, input logic b);
    logic [7:0] md;
    logic dis;
    md = c7 ? d & MASK_7BIT : d;
    dis = mpa && wen && !mpb;
    tx_q.push_back({md, pa, pa & (^md ^ od), mpa, mpa & mpb, st2 ? STOP_2 : STOP_1});
    rx_q.push_back({~dis, dis, pa & f & ~dis, !sy & b & ~dis, dis ? last_mark : mpa & mpb,
        dis ? last : md});
    if (!dis) begin
      last = md;
      last_mark = mpa & mpb;
    end
    if (mpa && mpb) wen = 1'b0;
    @(posedge i_clock);
    tx_in <= '{load: 1'b1, data: d, addr_mark: mpb};
    flip <= f;
    bad <= b;
    slow <= 1'($urandom_range(1));
    @(posedge i_clock);
    tx_in.load <= 1'b0;
    repeat (5) @(posedge i_clock);
  endtask
  always @(negedge i_clock) begin
    if (tx_out.valid === 1'b1) begin
      check(tx_seen, tx_q.pop_front());
    end
    if ((rx_out.accept | rx_out.discard) === 1'b1) begin
      check(rx_seen, rx_q.pop_front());
    end
  end
  initial begin
    #40000;
    fail_count++;
    print_verdict();
  end
  initial begin
    int cnt;
    void'($urandom(78175));
    wen = 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    reg_rd(OFF_MODE, rv);
    check({4'h0, rv}, 12'h000);
    check(cfg, CFG_RESET);
    reg_rd(2'h3, rv);
    check({4'h0, rv}, 12'h000);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      set_mode(modes[i]);
      send(8'($urandom), 1'($urandom_range(1)), 1'b0, 1'b0);
      send(8'hFF, 1'b1, 1'b0, 1'b0);
    end
    $display("test formats done");
    set_mode(8'h20);
    send(8'($urandom), 1'b0, 1'b1, 1'b0);
    send(8'($urandom), 1'b0, 1'b0, 1'b1);
    reg_rd(OFF_STAT, rv);
    check({4'h0, rv}, 12'(1 << POS_STAT_FERR));
    set_mode(8'h30);
    send(8'($urandom), 1'b0, 1'b1, 1'b0);
    set_mode(8'h04);
    send(8'h5A, 1'b0, 1'b1, 1'b0);
    reg_wr(OFF_WAIT, 8'h01);
    wen = 1'b1;
    send(8'($urandom), 1'b0, 1'b0, 1'b0);
    send(8'h3C, 1'b1, 1'b0, 1'b0);
    reg_rd(OFF_WAIT, rv);
    check({4'h0, rv}, 12'h000);
    $display("test errors and address wait done");
    for (int n = 0; n < 4; n++) begin
      set_mode(8'(n));
      repeat (70) @(negedge i_clock);
      cnt = 0;
      repeat (128) begin
        @(negedge i_clock);
        if (tick === 1'b1) cnt++;
      end
      check(12'(cnt), 12'd128 >> (2 * n));
    end
    $display("test prescaler done");
    print_verdict();
  end
endmodule
